//--- design/port_m_pkg.sv
// Shared constants and carrier types for the upper port M pin multiplexer.
// Assumes one bus clock, AHB-Lite register access and peripherals on the same clock.
// Functional notes
// - The block sets pin drive direction and resolves which function owns each shared pin.
// - The data register is eight bits at 0x0250, read and written at any time, zero after reset.
// - Pin 7 carries transmit and pin 6 receive of the third CAN, routed fifth CAN and fourth serial unit.
// - On pins 7 and 6 the third CAN beats the routed fifth CAN, which beats the serial unit, then GPIO.
// - Pin 5 carries transmit of the second CAN, routed first and fifth CAN, and the routed SPI clock.
// - Pin 5 order is second CAN, routed first CAN, routed fifth CAN, routed SPI, then GPIO.
// - A pin that no enabled peripheral claims is GPIO driven from its data register bit.
// - A data bit reads the stored value when its direction bit is 1, else the buffered pin level.
package port_m_pkg;

    localparam int unsigned PIN_COUNT = 8;

    // Register byte addresses
    localparam logic [11:0] ADDR_DATA = 12'h250;
    localparam logic [11:0] ADDR_DIR = 12'h260;
    localparam logic [11:0] ADDR_ROUTE = 12'h264;
    localparam logic [11:0] ADDR_OWNER = 12'h268;

    // Reset values
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [3:0] ROUTE_RESET = 4'h0;
    localparam logic [7:0] OE_N_RESET = 8'hff;

    // Route register bit positions
    localparam int unsigned ROUTE_FIFTH_CAN_CONTROLLER_HI = 0;
    localparam int unsigned ROUTE_FIFTH_CAN_CONTROLLER_MID = 1;
    localparam int unsigned ROUTE_FIRST_CAN_CONTROLLER_MID = 2;
    localparam int unsigned ROUTE_FIRST_SPI_UNIT_MID = 3;

    // Owner status field positions
    localparam int unsigned OWNER_HI_LSB = 0;
    localparam int unsigned OWNER_MID_LSB = 4;

    // Pin positions
    localparam int unsigned PIN_TX_HI = 7;
    localparam int unsigned PIN_RX_HI = 6;
    localparam int unsigned PIN_MID = 5;

    // Levels a peripheral sees when it does not own its pin
    localparam logic CAN_RX_IDLE = 1'b1;
    localparam logic SCI_RX_IDLE = 1'b1;
    localparam logic SPI_SCK_IDLE = 1'b0;

    typedef enum logic [2:0] {
        own_gpio,
        own_third_can_controller,
        own_fifth_can_controller,
        own_fourth_serial_interface,
        own_second_can_controller,
        own_first_can_controller,
        own_first_spi_unit
    } owner_e;

    typedef enum logic [2:0] {
        reg_none,
        reg_data,
        reg_dir,
        reg_route,
        reg_owner
    } reg_e;

    // Signals from the peripherals toward the pins
    typedef struct packed {
        logic third_can_enable;
        logic third_can_transmit_line;
        logic fifth_can_enable;
        logic fifth_can_transmit_line;
        logic fourth_serial_enable;
        logic serial_transmit_line;
        logic second_can_enable;
        logic second_can_transmit_line;
        logic first_can_enable;
        logic first_can_transmit_line;
        logic first_spi_enable;
        logic first_spi_sck_out;
        logic first_spi_sck_drive;
    } periph_out_s;

    // Signals from the pins toward the peripherals
    typedef struct packed {
        logic third_can_receive_line;
        logic fifth_can_receive_line;
        logic serial_receive_line;
        logic first_spi_sck_in;
    } periph_in_s;

endpackage

//--- design/pin_sync.sv
// Two-stage synchroniser for the raw port pin levels.
// Assumes pins change with no relation to hclk.
`timescale 1ns/1ns
module pin_sync
    import port_m_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [port_m_pkg::PIN_COUNT-1:0] pin_raw,
    output logic [port_m_pkg::PIN_COUNT-1:0] pin_sync_q
);
    typedef struct packed {
        logic [PIN_COUNT-1:0] stage1;
        logic [PIN_COUNT-1:0] stage2;
    } sync_state_s;

    sync_state_s st_q;
    sync_state_s st_d;

    // First stage feeds only the second stage
    always_comb
    begin
        st_d = st_q;
        for (int i = 0; i < PIN_COUNT; i++)
        begin
            st_d.stage1[i] = pin_raw[i];
            st_d.stage2[i] = st_q.stage1[i];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign pin_sync_q = st_q.stage2;
endmodule

//--- design/port_m_pin_priority_mux.sv
// Upper port M pin multiplexer with GPIO data, direction and routing registers.
// Assumes an AHB-Lite master on hclk and peripherals clocked by hclk.
`timescale 1ns/1ns
module port_m_pin_priority_mux
    import port_m_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire port_m_pkg::periph_out_s periph_out,
    output port_m_pkg::periph_in_s periph_in,
    input wire logic [port_m_pkg::PIN_COUNT-1:0] pin_in,
    output logic [port_m_pkg::PIN_COUNT-1:0] pin_out,
    output logic [port_m_pkg::PIN_COUNT-1:0] pin_oe_n
);
    import port_m_pkg::*;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] dir;
        logic [3:0] route;
        logic [7:0] pin_out;
        logic [7:0] pin_oe_n;
        periph_in_s rx;
        logic [2:0] owner_hi;
        logic [2:0] owner_mid;
        logic wr_pend;
        reg_e wr_sel;
        logic [31:0] rdata;
    } mux_state_s;

    mux_state_s st_q;
    mux_state_s st_d;
    logic [PIN_COUNT-1:0] pin_level;
    owner_e hi_owner;
    owner_e mid_owner;
    logic addr_phase;
    reg_e addr_sel;
    logic [7:0] data_view;
    logic [7:0] dir_view;
    logic [3:0] route_view;

    // Word address decode, shared by the write and read paths
    function automatic reg_e decode_addr(input logic [31:0] addr);
        reg_e sel;
        sel = reg_none;
        if (addr[31:12] == 20'h00000)
        begin
            case (addr[11:0])
                ADDR_DATA: sel = reg_data;
                ADDR_DIR: sel = reg_dir;
                ADDR_ROUTE: sel = reg_route;
                ADDR_OWNER: sel = reg_owner;
                default: sel = reg_none;
            endcase
        end
        return sel;
    endfunction

    // Owner of pins 7 and 6, highest priority first
    function automatic owner_e pick_hi(input periph_out_s p, input logic [3:0] route);
        owner_e o;
        if (p.third_can_enable)
            o = own_third_can_controller;
        else if (p.fifth_can_enable && route[ROUTE_FIFTH_CAN_CONTROLLER_HI])
            o = own_fifth_can_controller;
        else if (p.fourth_serial_enable)
            o = own_fourth_serial_interface;
        else
            o = own_gpio;
        return o;
    endfunction

    // Owner of pin 5, highest priority first
    function automatic owner_e pick_mid(input periph_out_s p, input logic [3:0] route);
        owner_e o;
        if (p.second_can_enable)
            o = own_second_can_controller;
        else if (p.first_can_enable && route[ROUTE_FIRST_CAN_CONTROLLER_MID])
            o = own_first_can_controller;
        else if (p.fifth_can_enable && route[ROUTE_FIFTH_CAN_CONTROLLER_MID])
            o = own_fifth_can_controller;
        else if (p.first_spi_enable && route[ROUTE_FIRST_SPI_UNIT_MID])
            o = own_first_spi_unit;
        else
            o = own_gpio;
        return o;
    endfunction

    // Pins come from outside the clock domain
    pin_sync u_pin_sync
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_raw(pin_in),
        .pin_sync_q(pin_level)
    );

    // Arbitration uses the live enables so a pin changes owner one cycle later
    assign hi_owner = pick_hi(periph_out, st_q.route);
    assign mid_owner = pick_mid(periph_out, st_q.route);

    // Address phase qualified by the bus-wide ready
    assign addr_phase = hsel && htrans[1] && hready;
    assign addr_sel = decode_addr(haddr);

    // Forward a write still in its data phase to a read right behind it
    always_comb
    begin
        data_view = st_q.data;
        dir_view = st_q.dir;
        route_view = st_q.route;
        if (st_q.wr_pend)
        begin
            case (st_q.wr_sel)
                reg_data: data_view = hwdata[7:0];
                reg_dir: dir_view = hwdata[7:0];
                reg_route: route_view = hwdata[3:0];
                default: data_view = st_q.data;
            endcase
        end
    end

    // Next state of registers, pins and peripheral inputs
    always_comb
    begin
        st_d = st_q;

        // Data phase of a write lands in its register
        st_d.data = data_view;
        st_d.dir = dir_view;
        st_d.route = route_view;

        // Address phase: remember writes, prepare read data now for zero wait
        st_d.wr_pend = addr_phase && hwrite;
        st_d.wr_sel = addr_sel;
        st_d.rdata = st_q.rdata;
        if (addr_phase && !hwrite)
        begin
            case (addr_sel)
                reg_data:
                begin
                    for (int i = 0; i < PIN_COUNT; i++)
                    begin
                        if (dir_view[i])
                            st_d.rdata[i] = data_view[i];
                        else
                            st_d.rdata[i] = pin_level[i];
                    end
                    st_d.rdata[31:8] = 24'h000000;
                end
                reg_dir: st_d.rdata = {24'h000000, dir_view};
                reg_route: st_d.rdata = {28'h0000000, route_view};
                reg_owner:
                begin
                    st_d.rdata = 32'h00000000;
                    st_d.rdata[OWNER_HI_LSB +: 3] = st_q.owner_hi;
                    st_d.rdata[OWNER_MID_LSB +: 3] = st_q.owner_mid;
                end
                default: st_d.rdata = 32'h00000000;
            endcase
        end

        // GPIO default for every pin: data bit out, direction bit drives
        for (int i = 0; i < PIN_COUNT; i++)
        begin
            st_d.pin_out[i] = st_q.data[i];
            st_d.pin_oe_n[i] = ~st_q.dir[i];
        end

        // Pins 7 and 6: transmit out on 7, receive in on 6
        case (hi_owner)
            own_third_can_controller:
            begin
                st_d.pin_out[PIN_TX_HI] = periph_out.third_can_transmit_line;
                st_d.pin_oe_n[PIN_TX_HI] = 1'b0;
                st_d.pin_oe_n[PIN_RX_HI] = 1'b1;
            end
            own_fifth_can_controller:
            begin
                st_d.pin_out[PIN_TX_HI] = periph_out.fifth_can_transmit_line;
                st_d.pin_oe_n[PIN_TX_HI] = 1'b0;
                st_d.pin_oe_n[PIN_RX_HI] = 1'b1;
            end
            own_fourth_serial_interface:
            begin
                st_d.pin_out[PIN_TX_HI] = periph_out.serial_transmit_line;
                st_d.pin_oe_n[PIN_TX_HI] = 1'b0;
                st_d.pin_oe_n[PIN_RX_HI] = 1'b1;
            end
            default:
            begin
                st_d.pin_out[PIN_TX_HI] = st_q.data[PIN_TX_HI];
            end
        endcase

        // Pin 5: CAN transmit drives, SPI clock drives only as master
        case (mid_owner)
            own_second_can_controller:
            begin
                st_d.pin_out[PIN_MID] = periph_out.second_can_transmit_line;
                st_d.pin_oe_n[PIN_MID] = 1'b0;
            end
            own_first_can_controller:
            begin
                st_d.pin_out[PIN_MID] = periph_out.first_can_transmit_line;
                st_d.pin_oe_n[PIN_MID] = 1'b0;
            end
            own_fifth_can_controller:
            begin
                st_d.pin_out[PIN_MID] = periph_out.fifth_can_transmit_line;
                st_d.pin_oe_n[PIN_MID] = 1'b0;
            end
            own_first_spi_unit:
            begin
                st_d.pin_out[PIN_MID] = periph_out.first_spi_sck_out;
                st_d.pin_oe_n[PIN_MID] = ~periph_out.first_spi_sck_drive;
            end
            default:
            begin
                st_d.pin_out[PIN_MID] = st_q.data[PIN_MID];
            end
        endcase

        // Losers see their idle level, never a pin they do not own
        st_d.rx.third_can_receive_line = (hi_owner == own_third_can_controller) ?
            pin_level[PIN_RX_HI] : CAN_RX_IDLE;
        st_d.rx.fifth_can_receive_line = (hi_owner == own_fifth_can_controller) ?
            pin_level[PIN_RX_HI] : CAN_RX_IDLE;
        st_d.rx.serial_receive_line = (hi_owner == own_fourth_serial_interface) ?
            pin_level[PIN_RX_HI] : SCI_RX_IDLE;
        st_d.rx.first_spi_sck_in = (mid_owner == own_first_spi_unit) ?
            pin_level[PIN_MID] : SPI_SCK_IDLE;

        // Owner status for software
        st_d.owner_hi = hi_owner;
        st_d.owner_mid = mid_owner;
    end

    // Single state register; pins float until software or a peripheral claims them
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_q.data <= DATA_RESET;
            st_q.dir <= DIR_RESET;
            st_q.route <= ROUTE_RESET;
            st_q.pin_out <= DATA_RESET;
            st_q.pin_oe_n <= OE_N_RESET;
            st_q.rx.third_can_receive_line <= CAN_RX_IDLE;
            st_q.rx.fifth_can_receive_line <= CAN_RX_IDLE;
            st_q.rx.serial_receive_line <= SCI_RX_IDLE;
            st_q.rx.first_spi_sck_in <= SPI_SCK_IDLE;
            st_q.owner_hi <= own_gpio;
            st_q.owner_mid <= own_gpio;
            st_q.wr_pend <= 1'b0;
            st_q.wr_sel <= reg_none;
            st_q.rdata <= 32'h00000000;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Zero-wait slave that always answers OKAY, so ready and response are constant
    logic hreadyout_q;
    logic hresp_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
        else
        begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end

    // Every output comes straight from a flip-flop, no logic after the register
    assign hrdata = st_q.rdata;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign periph_in = st_q.rx;
    assign pin_out = st_q.pin_out;
    assign pin_oe_n = st_q.pin_oe_n;
endmodule

//--- test/periph_agent.sv
// Far-side model: peripheral modules toward the block and the external pin wires.
// Assumes the bench sets enables and the external levels; all on hclk.
`timescale 1ns/1ns
module periph_agent
    import port_m_pkg::*;
(
    input wire logic hclk,
    input wire logic [5:0] en,
    input wire logic sck_drive,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] ext,
    output port_m_pkg::periph_out_s periph_out,
    output logic [7:0] pin_in
);
    logic [3:0] cnt_q = 4'h0;

    // Free count so every transmitter keeps changing; a stuck mux shows up
    always_ff @(posedge hclk)
        cnt_q <= cnt_q + 4'h1;

    // Enables third, fifth, serial, second, first, spi from the bench
    assign periph_out = {en[5], cnt_q[0], en[4], cnt_q[1], en[3], cnt_q[2], en[2], cnt_q[3],
        en[1], ~cnt_q[0], en[0], cnt_q[1], sck_drive};

    // Wire level: the block where it drives, else the outside device
    assign pin_in = (pin_oe_n & ext) | (~pin_oe_n & pin_out);
endmodule

//--- test/port_m_pin_priority_mux_asserts.sv
// Port-level checks for the upper port M pin multiplexer.
// Assumes hready tied to hreadyout and zero upper address bits.
`timescale 1ns/1ns
module port_m_pin_priority_mux_asserts
    import port_m_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire port_m_pkg::periph_out_s periph_out,
    input wire port_m_pkg::periph_in_s periph_in,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n
);
    periph_out_s po;
    logic wr_q;
    logic rd_q;
    logic [11:0] a_q;
    logic [7:0] data_q;
    logic [7:0] dir_q;
    logic [3:0] route_q;
    logic c4_hi;
    logic sci_hi;
    logic hi_per;
    logic hi_tx;
    logic c0_mid;
    logic c4_mid;
    logic spi_mid;
    logic mid_tx;
    logic mid_oe_n;

    // Shadow of the writable registers, updated in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            a_q <= 12'h000;
            data_q <= DATA_RESET;
            dir_q <= DIR_RESET;
            route_q <= ROUTE_RESET;
        end
        else
        begin
            wr_q <= hsel & htrans[1] & hready & hwrite;
            rd_q <= hsel & htrans[1] & hready & ~hwrite;
            a_q <= haddr[11:0];
            if (wr_q && a_q == ADDR_DATA)
                data_q <= hwdata[7:0];
            if (wr_q && a_q == ADDR_DIR)
                dir_q <= hwdata[7:0];
            if (wr_q && a_q == ADDR_ROUTE)
                route_q <= hwdata[3:0];
        end
    end

    // Expected owners, worked out from the two priority chains
    assign po = periph_out;
    assign c4_hi = ~po.third_can_enable & po.fifth_can_enable & route_q[ROUTE_FIFTH_CAN_CONTROLLER_HI];
    assign sci_hi = ~po.third_can_enable & ~c4_hi & po.fourth_serial_enable;
    assign hi_per = po.third_can_enable | c4_hi | sci_hi;
    assign hi_tx = po.third_can_enable ? po.third_can_transmit_line
        : c4_hi ? po.fifth_can_transmit_line : po.serial_transmit_line;
    assign c0_mid = po.first_can_enable & route_q[ROUTE_FIRST_CAN_CONTROLLER_MID];
    assign c4_mid = po.fifth_can_enable & route_q[ROUTE_FIFTH_CAN_CONTROLLER_MID];
    assign spi_mid = ~po.second_can_enable & ~c0_mid & ~c4_mid & po.first_spi_enable
        & route_q[ROUTE_FIRST_SPI_UNIT_MID];
    assign mid_tx = po.second_can_enable ? po.second_can_transmit_line
        : c0_mid ? po.first_can_transmit_line : c4_mid ? po.fifth_can_transmit_line
        : spi_mid ? po.first_spi_sck_out : data_q[5];
    assign mid_oe_n = spi_mid ? ~po.first_spi_sck_drive
        : (po.second_can_enable | c0_mid | c4_mid) ? 1'b0 : ~dir_q[5];

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_hi_tx_pin: assert property (1'b1 |=> pin_oe_n[7] == $past(~(hi_per | dir_q[7]))
        && (pin_oe_n[7] || pin_out[7] == $past(hi_per ? hi_tx : data_q[7])))
        else $error("pin 7 owner or level wrong");
    a_hi_rx_input: assert property (1'b1 |=> pin_oe_n[6] == $past(hi_per | ~dir_q[6]))
        else $error("pin 6 direction wrong");
    a_mid_pin: assert property (1'b1 |=> pin_oe_n[5] == $past(mid_oe_n)
        && (pin_oe_n[5] || pin_out[5] == $past(mid_tx)))
        else $error("pin 5 owner or level wrong");
    a_low_gpio: assert property (1'b1 |=> pin_oe_n[4:0] == $past(~dir_q[4:0]))
        else $error("low pin direction wrong");
    a_third_rx_idle: assert property (!po.third_can_enable |=>
        periph_in.third_can_receive_line == CAN_RX_IDLE) else $error("third rx not idle");
    a_sci_rx_idle: assert property (!sci_hi |=>
        periph_in.serial_receive_line == SCI_RX_IDLE) else $error("serial rx not idle");
    a_third_rx_pin: assert property (po.third_can_enable [*4] |->
        periph_in.third_can_receive_line == $past(pin_in[6], 3)) else $error("third rx lost");
    a_read_data: assert property (rd_q && a_q == ADDR_DATA |->
        ((hrdata[7:0] ^ data_q) & dir_q) == 8'h00 && hrdata[31:8] == 24'h000000
        && ((hrdata[7:0] ^ $past(pin_in, 3)) & ~dir_q) == 8'h00)
        else $error("data read wrong");
    a_fifth_rx_idle: assert property (!c4_hi |=>
        periph_in.fifth_can_receive_line == CAN_RX_IDLE) else $error("fifth rx not idle");
    a_spi_rx_idle: assert property (!spi_mid |=>
        periph_in.first_spi_sck_in == SPI_SCK_IDLE) else $error("spi clock in not idle");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");

    c_third_owns: cover property (po.third_can_enable [*4]);
    c_spi_mid: cover property (spi_mid);
    c_sci_hi: cover property (sci_hi);
endmodule

bind port_m_pin_priority_mux port_m_pin_priority_mux_asserts chk (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .periph_out, .periph_in, .pin_in, .pin_out, .pin_oe_n);

//--- test/port_m_pin_priority_mux_test.sv
// Self-checking bench for the upper port M pin multiplexer.
// Assumes one AHB-Lite master here and the peripheral agent on the far side.
`timescale 1ns/1ns
module port_m_pin_priority_mux_test
    import port_m_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    periph_out_s periph_out;
    periph_in_s periph_in;
    logic [7:0] pin_in;
    logic [7:0] pin_out;
    logic [7:0] pin_oe_n;
    logic [5:0] en = 6'h00;
    logic sck_drive = 1'b1;
    logic [7:0] ext = 8'h3c;
    logic [31:0] rd;
    int error_cnt = 0;
    int check_count = 0;
    logic [5:0] en_t [6] = '{6'h3f, 6'h1b, 6'h1b, 6'h11, 6'h1b, 6'h00};
    logic [3:0] rt_t [6] = '{4'hf, 4'hf, 4'ha, 4'h8, 4'h0, 4'hf};
    owner_e hi_t [6] = '{own_third_can_controller, own_fifth_can_controller, own_fourth_serial_interface, own_gpio, own_fourth_serial_interface, own_gpio};
    owner_e mid_t [6] = '{own_second_can_controller, own_first_can_controller, own_fifth_can_controller, own_first_spi_unit, own_gpio, own_gpio};

    port_m_pin_priority_mux DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .periph_out, .periph_in,
        .pin_in, .pin_out, .pin_oe_n);
    periph_agent far_side (.hclk, .en, .sck_drive, .pin_out, .pin_oe_n, .ext, .periph_out,
        .pin_in);

    // Free-running bus clock, 100 ns
    initial
        forever #50 hclk = ~hclk;

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask

    // One single word transfer; each phase held until hready is seen high
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
    begin
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    end
    endtask

    task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
    begin
        xfer(1'b0, a, 32'h0);
        check(nm, rd, exp);
    end
    endtask

    task automatic complete_run();
    begin
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask

    // Main sequence: registers, then every priority case, then receive paths
    initial
    begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rchk("dir reset", ADDR_DIR, 32'h0);
        rchk("unmapped", 32'h254, 32'h0);
        xfer(1'b1, ADDR_DIR, 32'hff);
        rchk("data reset", ADDR_DATA, 32'h0);
        xfer(1'b1, ADDR_DATA, 32'ha5);
        rchk("data out", ADDR_DATA, 32'ha5);
        check("gpio pins", {16'h0, pin_oe_n, pin_out}, 32'h00a5);
        xfer(1'b1, ADDR_DIR, 32'h0f);
        xfer(1'b1, ADDR_OWNER, 32'h77);
        repeat (2) @(posedge hclk);
        rchk("mixed read", ADDR_DATA, 32'h35);
        rchk("owner ro", ADDR_OWNER, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            xfer(1'b1, ADDR_ROUTE, 32'(rt_t[i]));
            en <= en_t[i];
            repeat (2) @(posedge hclk);
            rchk("owner", ADDR_OWNER, 32'({mid_t[i], 1'b0, hi_t[i]}));
        end
        xfer(1'b1, ADDR_ROUTE, 32'h8);
        en <= 6'h21;
        sck_drive <= 1'b0;
        repeat (5) @(posedge hclk);
        check("rx", {28'h0, periph_in}, {28'h0, ext[6], CAN_RX_IDLE, SCI_RX_IDLE, ext[5]});
        check("oe", {24'h0, pin_oe_n}, 32'h70);
        complete_run();
    end

    // Cuts a hang short; the sequence needs well under a thousand cycles
    initial
    begin
        #(5000 * 100);
        error_cnt++;
        complete_run();
    end
endmodule
